/* File: rtl/xstack_cfg.svh */
// Encodings, field positions and special addresses of the extended stack instructions
`ifndef XSTACK_CFG_SVH
`define XSTACK_CFG_SVH
`define OPW_MOVE_HI      8'hEB
`define OPW_SUB_HI       8'hE9
`define OPW_PUSH_HI      8'hFA
`define OPW_CALL_THROUGH_WORKING_REG        16'h0014
`define OPW_SECOND_HI    4'hF
`define SEL_FRAME        2'h3
`define SEL_SW_FRAME     2'h2
`define ADDR_PC_LOW      12'hFF9
`define ADDR_TOS_LOW     12'hFFD
`define ADDR_TOS_HIGH    12'hFFE
`define ADDR_TOS_UPPER   12'hFFF
`define ADDR_INDF_MASK   12'hFF8
`define ADDR_INDF_BASE   12'hFE8
`define ADDR_INDF_ALT    12'hFE0
`define ADDR_INDF_ALT2   12'hFD8
`define ZERO_BYTE        8'h00
`define ZERO_ADDR        12'h000
`define ONE_ADDR         12'h001
`define PC_STEP          21'h000002
`endif

/* File: rtl/xstack_pkg.sv */
// Types shared by the extended stack instruction block
package xstack_pkg;
    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_MOVE_F   = 2'b01,
        ST_MOVE_S   = 2'b10,
        ST_RET_WAIT = 2'b11
    } exec_state_e;
    typedef logic [11:0] daddr_t;
endpackage

/* File: rtl/addr_calc_if.sv */
// Address calculation interface between executor and address unit
`timescale 1ns/1ps
interface addr_calc_if;
    logic [11:0] base;
    logic [6:0]  offset;
    logic [11:0] sum;
    logic        is_indirect;
    logic        is_protected;
    modport user (output base, output offset, input sum, input is_indirect, input is_protected);
    modport unit (input base, input offset, output sum, output is_indirect, output is_protected);
endinterface

/* File: rtl/addr_calc.sv */
// Frame-relative address adder with special-register classification
`timescale 1ns/1ps
`include "xstack_cfg.svh"
module addr_calc (
    addr_calc_if.unit a
);
    // Wrapping sum, no carry kept
    assign a.sum = 12'(a.base + {5'h00, a.offset});
    // Indirect-access registers sit at three 8-byte groups
    assign a.is_indirect = ((a.sum & `ADDR_INDF_MASK) == `ADDR_INDF_BASE)
                         | ((a.sum & `ADDR_INDF_MASK) == `ADDR_INDF_ALT)
                         | ((a.sum & `ADDR_INDF_MASK) == `ADDR_INDF_ALT2);
    // Program counter low and stack top bytes
    assign a.is_protected = (a.sum == `ADDR_PC_LOW) | (a.sum == `ADDR_TOS_LOW)
                          | (a.sum == `ADDR_TOS_HIGH) | (a.sum == `ADDR_TOS_UPPER);
endmodule

/* File: rtl/extended_stack_instr_exec.sv */
// Executor for the extended software-stack instructions
// How it works
// - Move-to-file source is frame pointer plus 7-bit offset.
// - Move-to-file destination is the 12-bit literal of word two.
// - Move-to-file decodes as EB with bit 7 clear.
// - Indexed-to-indexed source and destination both frame pointer plus offset.
// - Second word of indexed-to-indexed starts with 1111.
// - Program counter low and stack top bytes never written by indexed moves.
// - Source in an indirect register reads as zero.
// - Destination in an indirect register makes an indexed-to-indexed move a no-operation; move-to-file still writes it.
// - Push literal writes at frame pointer then decrements it; one cycle.
// - Subtract from pointer takes 6-bit literal off selected pointer 0..2.
// - Select 11 subtracts from frame pointer and returns from stack top.
// - Subtract-and-return takes two cycles, second a no-operation.
// - None of these instructions changes arithmetic status flags.
// - Call through working reg pushes next address, loads pc from latches.
// - Extended instructions decode only when the enable bit is set.
`timescale 1ns/1ps
`include "xstack_cfg.svh"
module extended_stack_instr_exec #(
    parameter int AW = 12
) (
    // Clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_resetn,
    // Configuration
    input  wire logic          i_extended_set_enable,
    // Fetch and decode
    input  wire logic          i_instr_valid,
    input  wire logic [15:0]   i_instr,
    input  wire logic [20:0]   i_pc,
    input  wire logic [7:0]    i_working_register,
    input  wire logic [7:0]    i_program_counter_high_latch,
    input  wire logic [7:0]    i_program_counter_upper_latch,
    input  wire logic [20:0]   i_return_stack_top,
    input  wire logic [7:0]    i_mem_rdata,
    output logic               o_claimed,
    output logic               o_busy,
    // Data memory
    output logic [AW-1:0]      o_mem_raddr,
    output logic               o_mem_rd,
    output logic [AW-1:0]      o_mem_waddr,
    output logic [7:0]         o_mem_wdata,
    output logic               o_mem_we,
    // Pointers
    output logic [AW-1:0]      o_pointer0,
    output logic [AW-1:0]      o_pointer1,
    output logic [AW-1:0]      o_software_frame_pointer,
    // Program counter and return stack
    output logic [20:0]        o_pc_load_value,
    output logic               o_pc_load,
    output logic [20:0]        o_stack_push_value,
    output logic               o_stack_push,
    output logic               o_stack_pop,
    output logic               o_status_write
);
    xstack_pkg::exec_state_e state_r;
    xstack_pkg::exec_state_e state_nxt;
    logic [AW-1:0] ptr_r [3];
    logic [7:0]    hold_r;
    logic          hold_zero_r;
    logic [6:0]    dst_off;
    logic          is_move, is_move_f, is_push, is_sub, is_call_through_working_reg, is_second;
    logic [1:0]    sel;
    addr_calc_if   src_if ();
    addr_calc_if   dst_if ();

    addr_calc u_src (.a(src_if));
    addr_calc u_dst (.a(dst_if));

    // Wrapping 12-bit subtract, no borrow
    function automatic logic [AW-1:0] sub_wrap(input logic [AW-1:0] v, input logic [AW-1:0] k);
        sub_wrap = AW'(v - k);
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign is_move   = i_extended_set_enable && i_instr[15:8] == `OPW_MOVE_HI;
    assign is_move_f = is_move && !i_instr[7];
    assign is_push   = i_extended_set_enable && i_instr[15:8] == `OPW_PUSH_HI;
    assign is_sub    = i_extended_set_enable && i_instr[15:8] == `OPW_SUB_HI;
    assign is_call_through_working_reg  = i_extended_set_enable && i_instr == `OPW_CALL_THROUGH_WORKING_REG;
    assign is_second = i_instr[15:12] == `OPW_SECOND_HI;
    assign sel       = i_instr[7:6];
    assign dst_off   = i_instr[6:0];

    // Source from frame pointer plus offset of first word
    assign src_if.base   = ptr_r[`SEL_SW_FRAME];
    assign src_if.offset = i_instr[6:0];
    assign dst_if.base   = ptr_r[`SEL_SW_FRAME];
    assign dst_if.offset = dst_off;

    // Next state
    always_comb begin
        state_nxt = xstack_pkg::ST_IDLE;
        case (state_r)
            xstack_pkg::ST_IDLE: begin
                if (i_instr_valid && is_move) begin
                    state_nxt = is_move_f ? xstack_pkg::ST_MOVE_F : xstack_pkg::ST_MOVE_S;
                end else if (i_instr_valid && is_sub && sel == `SEL_FRAME) begin
                    state_nxt = xstack_pkg::ST_RET_WAIT;
                end
            end
            xstack_pkg::ST_MOVE_F,
            xstack_pkg::ST_MOVE_S,
            xstack_pkg::ST_RET_WAIT: begin
                if (!i_instr_valid) begin
                    state_nxt = state_r;
                end
            end
            default: state_nxt = xstack_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= xstack_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Indirect-source zero flag captured in the first cycle
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_zero_r <= 1'b0;
        end else if (state_r == xstack_pkg::ST_IDLE && i_instr_valid && is_move) begin
            hold_zero_r <= src_if.is_indirect;
        end
    end
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mem_raddr <= `ZERO_ADDR;
            o_mem_rd    <= 1'b0;
        end else begin
            // Address held through a stalled second word so the read data stays put
            if (state_r == xstack_pkg::ST_IDLE && i_instr_valid && is_move) begin
                o_mem_raddr <= src_if.sum;
            end
            o_mem_rd    <= state_r == xstack_pkg::ST_IDLE && i_instr_valid && is_move
                           && !src_if.is_indirect;
        end
    end
    // Memory data is used in the same cycle as the read strobe
    always_comb begin
        hold_r = hold_zero_r ? `ZERO_BYTE : i_mem_rdata;
    end

    // ------------------------------------------------------------
    // Pointers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < 3; i++) begin
                ptr_r[i] <= `ZERO_ADDR;
            end
        end else if (state_r == xstack_pkg::ST_IDLE && i_instr_valid) begin
            if (is_push) begin
                ptr_r[`SEL_SW_FRAME] <= sub_wrap(ptr_r[`SEL_SW_FRAME], `ONE_ADDR);
            end else if (is_sub && sel == `SEL_FRAME) begin
                ptr_r[`SEL_SW_FRAME] <= sub_wrap(ptr_r[`SEL_SW_FRAME], {6'h00, i_instr[5:0]});
            end else if (is_sub) begin
                ptr_r[sel] <= sub_wrap(ptr_r[sel], {6'h00, i_instr[5:0]});
            end
        end
    end
    always_comb begin
        o_pointer0               = ptr_r[0];
        o_pointer1               = ptr_r[1];
        o_software_frame_pointer = ptr_r[`SEL_SW_FRAME];
    end

    // ------------------------------------------------------------
    // Memory write
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mem_we    <= 1'b0;
            o_mem_waddr <= `ZERO_ADDR;
            o_mem_wdata <= `ZERO_BYTE;
        end else begin
            o_mem_we <= 1'b0;
            if (state_r == xstack_pkg::ST_IDLE && i_instr_valid && is_push) begin
                o_mem_we    <= 1'b1;
                o_mem_waddr <= ptr_r[`SEL_SW_FRAME];
                o_mem_wdata <= i_instr[7:0];
            end else if (state_r == xstack_pkg::ST_MOVE_F && i_instr_valid) begin
                o_mem_waddr <= i_instr[11:0];
                o_mem_wdata <= hold_r;
                o_mem_we    <= !(i_instr[11:0] == `ADDR_PC_LOW || i_instr[11:0] == `ADDR_TOS_LOW
                               || i_instr[11:0] == `ADDR_TOS_HIGH
                               || i_instr[11:0] == `ADDR_TOS_UPPER);
            end else if (state_r == xstack_pkg::ST_MOVE_S && i_instr_valid) begin
                o_mem_waddr <= dst_if.sum;
                o_mem_wdata <= hold_r;
                o_mem_we    <= is_second && !dst_if.is_indirect && !dst_if.is_protected;
            end
        end
    end

    // ------------------------------------------------------------
    // Program counter, return stack, claim
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pc_load          <= 1'b0;
            o_pc_load_value    <= 21'h000000;
            o_stack_push       <= 1'b0;
            o_stack_push_value <= 21'h000000;
            o_stack_pop        <= 1'b0;
            o_claimed          <= 1'b0;
            o_busy             <= 1'b0;
            o_status_write     <= 1'b0;
        end else begin
            o_pc_load      <= 1'b0;
            o_stack_push   <= 1'b0;
            o_stack_pop    <= 1'b0;
            o_status_write <= 1'b0;
            o_busy         <= state_nxt != xstack_pkg::ST_IDLE;
            o_claimed      <= i_instr_valid && (state_r != xstack_pkg::ST_IDLE
                              || is_move || is_push || is_sub || is_call_through_working_reg);
            if (state_r == xstack_pkg::ST_IDLE && i_instr_valid) begin
                if (is_sub && sel == `SEL_FRAME) begin
                    o_pc_load       <= 1'b1;
                    o_pc_load_value <= i_return_stack_top;
                    o_stack_pop     <= 1'b1;
                end else if (is_call_through_working_reg) begin
                    o_stack_push       <= 1'b1;
                    o_stack_push_value <= 21'(i_pc + `PC_STEP);
                    o_pc_load          <= 1'b1;
                    o_pc_load_value    <= {i_program_counter_upper_latch[4:0],
                                           i_program_counter_high_latch, i_working_register};
                end
            end
        end
    end
endmodule

/* File: bench/mem_stack_model.sv */
// Data memory and return stack model beside the executor
`timescale 1ns/1ps
module mem_stack_model (
    // Clock
    input  wire logic        i_clock,
    // Data memory
    input  wire logic [11:0] i_raddr,
    input  wire logic [11:0] i_waddr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_we,
    output logic      [7:0]  o_rdata,
    // Return stack
    input  wire logic [20:0] i_push_value,
    input  wire logic        i_push,
    input  wire logic        i_pop,
    output logic      [20:0] o_top
);
    logic [7:0]  mem_r [4096];
    logic [20:0] stk_r [8];
    logic [2:0]  sp_r = 3'h0;
    // Known pattern so every read is predictable
    initial for (int i = 0; i < 4096; i++) mem_r[i] = 8'(i) ^ 8'h5A;
    initial for (int i = 0; i < 8; i++) stk_r[i] = 21'h000100 + 21'(i);
    assign o_rdata = mem_r[i_raddr];
    assign o_top   = stk_r[sp_r];
    // Writes, pushes and pops
    always @(posedge i_clock) begin
        if (i_we) mem_r[i_waddr] <= i_wdata;
        if (i_push) begin
            sp_r <= sp_r + 3'h1;
            stk_r[sp_r + 3'h1] <= i_push_value;
        end else if (i_pop) begin
            sp_r <= sp_r - 3'h1;
        end
    end
endmodule

/* File: bench/xstack_chk.sv */
// Port checks for the extended stack instruction executor
`timescale 1ns/1ps
`include "xstack_cfg.svh"
module xstack_chk #(
    parameter int AW = 12
) (
    // Clock, reset, decode side
    input wire logic          i_clock,
    input wire logic          i_resetn,
    input wire logic          i_extended_set_enable,
    input wire logic          i_instr_valid,
    input wire logic [15:0]   i_instr,
    input wire logic [20:0]   i_pc,
    input wire logic [20:0]   i_return_stack_top,
    input wire logic          o_claimed,
    input wire logic          o_busy,
    // Results
    input wire logic [AW-1:0] o_mem_waddr,
    input wire logic [7:0]    o_mem_wdata,
    input wire logic          o_mem_we,
    input wire logic [AW-1:0] o_software_frame_pointer,
    input wire logic [20:0]   o_pc_load_value,
    input wire logic          o_pc_load,
    input wire logic [20:0]   o_stack_push_value,
    input wire logic          o_stack_push,
    input wire logic          o_stack_pop,
    input wire logic          o_status_write
);
    logic go;
    // A first word is taken this cycle
    assign go = i_instr_valid && i_extended_set_enable && !o_busy;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    status_untouched_a: assert property (!o_status_write)
        else $error("status write raised");
    push_store_a: assert property (go && i_instr[15:8] == `OPW_PUSH_HI |=> o_mem_we
        && o_mem_wdata == 8'($past(i_instr)) && o_mem_waddr == $past(o_software_frame_pointer))
        else $error("push store wrong");
    push_step_a: assert property (go && i_instr[15:8] == `OPW_PUSH_HI |=>
        o_software_frame_pointer == $past(o_software_frame_pointer) - AW'(1))
        else $error("push decrement wrong");
    move_wait_a: assert property (go && i_instr[15:8] == `OPW_MOVE_HI |=> o_busy && !o_mem_we)
        else $error("move first cycle wrong");
    ret_load_a: assert property (go && i_instr[15:6] == {`OPW_SUB_HI, `SEL_FRAME} |=> o_pc_load
        && o_stack_pop && o_pc_load_value == $past(i_return_stack_top))
        else $error("return load wrong");
    ret_idle_a: assert property (go && i_instr[15:6] == {`OPW_SUB_HI, `SEL_FRAME} |->
        ##2 !o_mem_we && !o_pc_load && !o_stack_push)
        else $error("return second cycle not idle");
    call_push_a: assert property (go && i_instr == `OPW_CALL_THROUGH_WORKING_REG |=> o_stack_push
        && o_stack_push_value == $past(i_pc) + `PC_STEP)
        else $error("call push wrong");
    off_ignore_a: assert property (i_instr_valid && !i_extended_set_enable && !o_busy |=> !o_claimed)
        else $error("claimed while disabled");
    dest_guard_a: assert property (o_mem_we && $past(o_busy) |-> !(o_mem_waddr inside
        {`ADDR_PC_LOW, `ADDR_TOS_LOW, `ADDR_TOS_HIGH, `ADDR_TOS_UPPER}))
        else $error("move wrote a guarded byte");
endmodule
bind extended_stack_instr_exec xstack_chk #(.AW(AW)) i_chk (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_extended_set_enable(i_extended_set_enable),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_pc(i_pc), .i_return_stack_top(i_return_stack_top),
    .o_claimed(o_claimed), .o_busy(o_busy), .o_mem_waddr(o_mem_waddr), .o_mem_wdata(o_mem_wdata),
    .o_mem_we(o_mem_we), .o_software_frame_pointer(o_software_frame_pointer),
    .o_pc_load_value(o_pc_load_value), .o_pc_load(o_pc_load), .o_stack_push_value(o_stack_push_value),
    .o_stack_push(o_stack_push), .o_stack_pop(o_stack_pop), .o_status_write(o_status_write));

/* File: bench/tb_top.sv */
// Self-checking bench for the extended stack instruction executor
`timescale 1ns/1ps
module tb_top;
    logic        i_clock = 1'b0;
    logic        i_resetn = 1'b0;
    logic        i_extended_set_enable = 1'b1;
    logic        i_instr_valid = 1'b0;
    logic [15:0] i_instr = 16'h0000;
    logic [20:0] i_pc = 21'h001004;
    logic [7:0]  i_working_register = 8'h06;
    logic [7:0]  i_program_counter_high_latch = 8'h10;
    logic [7:0]  i_program_counter_upper_latch = 8'h0A;
    logic [20:0] i_return_stack_top, o_pc_load_value, o_stack_push_value, exp_pc;
    logic [7:0]  i_mem_rdata, o_mem_wdata;
    logic        o_claimed, o_busy, o_mem_rd, o_mem_we, o_pc_load, o_stack_push, o_stack_pop, o_status_write;
    logic [11:0] o_mem_raddr, o_mem_waddr, o_pointer0, o_pointer1, o_software_frame_pointer;
    logic [11:0] fp = 12'h000;
    int          fails = 0;
    int          tests_run = 0;
    extended_stack_instr_exec #(.AW(12)) i_dut (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_extended_set_enable(i_extended_set_enable),
        .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_pc(i_pc), .i_working_register(i_working_register),
        .i_program_counter_high_latch(i_program_counter_high_latch),
        .i_program_counter_upper_latch(i_program_counter_upper_latch),
        .i_return_stack_top(i_return_stack_top), .i_mem_rdata(i_mem_rdata), .o_claimed(o_claimed),
        .o_busy(o_busy), .o_mem_raddr(o_mem_raddr), .o_mem_rd(o_mem_rd), .o_mem_waddr(o_mem_waddr),
        .o_mem_wdata(o_mem_wdata), .o_mem_we(o_mem_we), .o_pointer0(o_pointer0), .o_pointer1(o_pointer1),
        .o_software_frame_pointer(o_software_frame_pointer), .o_pc_load_value(o_pc_load_value),
        .o_pc_load(o_pc_load), .o_stack_push_value(o_stack_push_value), .o_stack_push(o_stack_push),
        .o_stack_pop(o_stack_pop), .o_status_write(o_status_write));
    mem_stack_model i_mem (.i_clock(i_clock), .i_raddr(o_mem_raddr), .i_waddr(o_mem_waddr),
        .i_wdata(o_mem_wdata), .i_we(o_mem_we), .o_rdata(i_mem_rdata), .i_push_value(o_stack_push_value),
        .i_push(o_stack_push), .i_pop(o_stack_pop), .o_top(i_return_stack_top));
    // Clock
    always #5 i_clock = ~i_clock;
    task automatic chk(input string what, input logic [20:0] seen, input logic [20:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic issue(input logic [15:0] w);
        i_instr_valid = 1'b1;
        i_instr = w;
        @(posedge i_clock);
        #1;
    endtask
    task automatic idle();
        i_instr_valid = 1'b0;
        @(posedge i_clock);
        #1;
    endtask
    task automatic t_basic();
        i_extended_set_enable = 1'b0;
        issue(16'hFA08);
        chk("off claimed", o_claimed, 21'h0);
        chk("off we", o_mem_we, 21'h0);
        i_extended_set_enable = 1'b1;
        issue(16'hFA08);
        chk("push addr", o_mem_waddr, 21'(fp));
        chk("push data", o_mem_wdata, 21'h08);
        fp = fp - 12'h001;
        chk("push fp", o_software_frame_pointer, 21'(fp));
        for (int s = 0; s < 3; s++) issue({8'hE9, 2'(s), 6'h3F});
        fp = fp - 12'h03F;
        chk("ptr0", o_pointer0, 21'hFC1);
        chk("ptr1", o_pointer1, 21'hFC1);
        chk("frame", o_software_frame_pointer, 21'(fp));
        issue(16'h0014);
        chk("call push", o_stack_push, 21'h1);
        chk("call load", o_pc_load, 21'h1);
        chk("call ret", o_stack_push_value, 21'h001006);
        chk("call pc", o_pc_load_value, 21'h0A1006);
        idle();
        $display("test basic done");
    endtask
    task automatic t_moves();
        logic [6:0]  src [6] = '{7'h05, 7'h05, 7'h18, 7'h05, 7'h05, 7'h05};
        logic [15:0] w2 [6] = '{16'hF123, 16'hF07F, 16'hF510, 16'hF028, 16'hF039, 16'h0006};
        logic [20:0] ad [6] = '{21'h123, 21'h03F, 21'hFD0, 21'h0, 21'h0, 21'h0};
        logic [20:0] dt [6] = '{21'h9F, 21'h9F, 21'h00, 21'h0, 21'h0, 21'h0};
        for (int i = 0; i < 6; i++) begin
            issue({8'hEB, (i > 0), src[i]});
            chk("rd", o_mem_rd, 21'(src[i] != 7'h18));
            if (src[i] == 7'h05) chk("raddr", o_mem_raddr, 21'(fp + 12'h005));
            issue(w2[i]);
            chk("we", o_mem_we, 21'(i < 3));
            if (i < 3) chk("waddr", o_mem_waddr, ad[i]);
            if (i < 3) chk("wdata", o_mem_wdata, dt[i]);
        end
        issue(16'hF006);
        chk("stray we", o_mem_we, 21'h0);
        chk("stray claim", o_claimed, 21'h0);
        issue(16'hEB05);
        issue(16'hFFFD);
        chk("file guard we", o_mem_we, 21'h0);
        idle();
        $display("test moves done");
    endtask
    task automatic t_return();
        exp_pc = 21'h001006;
        issue(16'hE9C3);
        fp = fp - 12'h003;
        chk("ret pop", o_stack_pop, 21'h1);
        chk("ret load", o_pc_load, 21'h1);
        chk("ret busy", o_busy, 21'h1);
        chk("ret pc", o_pc_load_value, exp_pc);
        chk("ret fp", o_software_frame_pointer, 21'(fp));
        issue(16'hFA55);
        chk("ret nop", o_mem_we, 21'h0);
        chk("ret nop claim", o_claimed, 21'h1);
        chk("ret nop fp", o_software_frame_pointer, 21'(fp));
        idle();
        chk("ret status", o_status_write, 21'h0);
        $display("test return done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge i_clock);
        #1;
        i_resetn = 1'b1;
        t_basic();
        t_moves();
        t_return();
        print_verdict();
    end
    // Hang guard
    initial begin
        #100000;
        fails++;
        print_verdict();
    end
endmodule
